// >>> verilog/rmc_consts.svh
`ifndef RMC_CONSTS_SVH
`define RMC_CONSTS_SVH
`define RMC_CLK_MHZ 200
`define RMC_PD2STBY_US 150
`define RMC_PD2STBY_CYC (`RMC_PD2STBY_US * `RMC_CLK_MHZ)
`define RMC_STBY2A_US 130
`define RMC_STBY2A_CYC (`RMC_STBY2A_US * `RMC_CLK_MHZ)
`define RMC_CE_MIN_US 10
`define RMC_CE_MIN_CYC (`RMC_CE_MIN_US * `RMC_CLK_MHZ + 1)
`define RMC_RPD_US 40
`define RMC_RPD_CYC (`RMC_RPD_US * `RMC_CLK_MHZ)
`define RMC_TXMAX_US 4000
`define RMC_TXMAX_CYC (`RMC_TXMAX_US * `RMC_CLK_MHZ)
`define RMC_RATE_1M 2'h0
`define RMC_RATE_2M 2'h1
`define RMC_RATE_250K 2'h2
`define RMC_RPD_REG_IDX 8'h09
`define RMC_RPD_BIT 0
`define RMC_CNT_W 20
`endif

// >>> verilog/rmc_pkg.sv
package rmc_pkg;
    typedef enum logic [2:0]
    {
        RMC_PDN    = 3'h0,
        RMC_PU_WT  = 3'h1,
        RMC_STBY1  = 3'h3,
        RMC_SETTLE = 3'h2,
        RMC_RX     = 3'h6,
        RMC_TX     = 3'h7,
        RMC_STBY2  = 3'h5
    } rmc_mode_type;

    typedef struct packed
    {
        logic       power_up_bit;
        logic       primary_receiver_select;
        logic       chip_enable;
        logic       auto_protocol_en;
        logic [1:0] air_rate_select;
    } rmc_ctrl_type;

    typedef struct packed
    {
        logic pkt_valid;
        logic pkt_addr_match;
        logic pkt_crc_ok;
    } rmc_rxev_type;
endpackage

// >>> verilog/rmc_timer.sv
`include "rmc_consts.svh"
module rmc_timer
#(
    parameter int W = `RMC_CNT_W
)
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         run,
    input  wire logic [W-1:0] limit,
    output logic              done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done_d;
    logic         done_q;

    // Counter restarts whenever run drops, so every interval is measured fresh.
    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (!run)
        begin
            cnt_d = '0;
        end
        else if (cnt_q >= limit)
        begin
            done_d = 1'b1;
        end
        else
        begin
            cnt_d = cnt_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done = done_q & run;
endmodule

// >>> verilog/rmc_top.sv
// Functional notes
// - Enter power down after reset completes.
// - Register values and SPI kept in standby.
// - Power-up bit low forces power down.
// - Power-up enters standby-I within 150us.
// - Active only with chip-enable; else standby-I.
// - Transmitter, enable high, FIFO empty: standby-II.
// - Standby-II new packet: settle 130us, send.
// - RX when power-up, receiver select, enable.
// - Valid addressed CRC-good packet stored.
// - Full RX FIFO discards valid packet.
// - Stay RX until host leaves; protocol exception.
// - Power flag after 40us filtered detection.
// - TX needs payload, enable over 10us.
// - After packet: standby-I, next, or standby-II.
// - TX mode never exceeds 4ms.
// - Enable high drains and refilled FIFO continues.
// - Standby-II sends when chip-select returns high.
// - Enable pulse sends one packet, standby-I.
// - TX/RX turnaround uses 130us settle.
// - Air rate from setup register bits.
// - Power flag readable register 09 bit 0.
// - Power flag frozen on packet or enable low.
`include "rmc_consts.svh"
module rmc_top
#(
    parameter int PD2STBY_CYC = `RMC_PD2STBY_CYC,
    parameter int STBY2A_CYC  = `RMC_STBY2A_CYC,
    parameter int CE_MIN_CYC  = `RMC_CE_MIN_CYC,
    parameter int RPD_CYC     = `RMC_RPD_CYC,
    parameter int TXMAX_CYC   = `RMC_TXMAX_CYC
)
(
    input  wire logic                 REF_CLK,
    input  wire logic                 RST_B,
    input  wire rmc_pkg::rmc_ctrl_type CTRL,
    input  wire logic                 SYNC_RST,
    input  wire logic                 CHIP_SELECT_B,
    input  wire logic                 TX_FIFO_EMPTY,
    input  wire logic                 RX_FIFO_FULL,
    input  wire rmc_pkg::rmc_rxev_type RX_EVENT,
    input  wire logic                 TX_PKT_DONE,
    input  wire logic                 POWER_DETECT_RAW,
    output logic                      RX_STORE,
    output logic                      RX_DISCARD,
    output logic                      TX_START,
    output logic                      TX_ABORT,
    output logic                      SYNTH_ON,
    output logic                      CLK_BUF_ON,
    output logic                      SPI_ENABLE,
    output logic [1:0]                AIR_RATE,
    output logic                      RX_ACTIVE,
    output logic                      TX_ACTIVE,
    output logic                      RECEIVED_POWER_FLAG,
    output logic [2:0]                MODE
);
    localparam int W = `RMC_CNT_W;

    rmc_pkg::rmc_mode_type mode_q;
    rmc_pkg::rmc_mode_type mode_d;
    logic                  settle_rx_q;
    logic                  settle_rx_d;
    logic                  pulse_q;
    logic                  pulse_d;
    logic                  sent_q;
    logic                  sent_d;
    logic                  load_pend_q;
    logic                  load_pend_d;
    logic [2:0]            det_s_q;
    logic                  det_f_q;
    logic                  det_f_d;
    logic                  rpd_q;
    logic                  rpd_d;
    logic                  rx_store_q;
    logic                  rx_store_d;
    logic                  rx_disc_q;
    logic                  rx_disc_d;
    logic                  tx_start_q;
    logic                  tx_start_d;
    logic                  tx_abort_q;
    logic                  tx_abort_d;
    logic [1:0]            rate_q;
    logic [1:0]            rate_d;
    logic                  cs_q;
    logic                  ce_q;
    logic                  pu_done;
    logic                  set_done;
    logic                  ce_long;
    logic                  rpd_done;
    logic                  tx_over;
    logic                  pu;
    logic                  prx;
    logic                  ce;
    logic                  valid_pkt;

    assign pu  = CTRL.power_up_bit;
    assign prx = CTRL.primary_receiver_select;
    assign ce  = CTRL.chip_enable;
    assign valid_pkt = RX_EVENT.pkt_valid & RX_EVENT.pkt_addr_match & RX_EVENT.pkt_crc_ok;

    rmc_timer #(.W(W)) u_pu
    (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .run   (mode_q == rmc_pkg::RMC_PU_WT),
        .limit (W'(PD2STBY_CYC - 1)),
        .done  (pu_done)
    );

    rmc_timer #(.W(W)) u_set
    (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .run   (mode_q == rmc_pkg::RMC_SETTLE),
        .limit (W'(STBY2A_CYC - 1)),
        .done  (set_done)
    );

    rmc_timer #(.W(W)) u_ce
    (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .run   (ce),
        .limit (W'(CE_MIN_CYC - 1)),
        .done  (ce_long)
    );

    rmc_timer #(.W(W)) u_rpd
    (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .run   (det_f_q && mode_q == rmc_pkg::RMC_RX),
        .limit (W'(RPD_CYC - 1)),
        .done  (rpd_done)
    );

    rmc_timer #(.W(W)) u_tx
    (
        .clk   (REF_CLK),
        .rst_b (RST_B),
        .run   (mode_q == rmc_pkg::RMC_TX),
        .limit (W'(TXMAX_CYC - 1)),
        .done  (tx_over)
    );

    always_comb
    begin
        mode_d      = mode_q;
        settle_rx_d = settle_rx_q;
        pulse_d     = pulse_q;
        sent_d      = sent_q;
        tx_start_d  = 1'b0;
        tx_abort_d  = 1'b0;
        load_pend_d = load_pend_q | (CHIP_SELECT_B & ~cs_q & ~TX_FIFO_EMPTY);
        if (ce && !ce_q)
        begin
            pulse_d = 1'b1;
            sent_d  = 1'b0;
        end
        case (mode_q)
            rmc_pkg::RMC_PDN:
            begin
                if (pu)
                begin
                    mode_d = rmc_pkg::RMC_PU_WT;
                end
            end
            rmc_pkg::RMC_PU_WT:
            begin
                if (pu_done)
                begin
                    mode_d = rmc_pkg::RMC_STBY1;
                end
            end
            rmc_pkg::RMC_STBY1:
            begin
                if (ce && prx)
                begin
                    mode_d      = rmc_pkg::RMC_SETTLE;
                    settle_rx_d = 1'b1;
                end
                else if (ce_long && !prx && !TX_FIFO_EMPTY && !sent_q)
                begin
                    mode_d      = rmc_pkg::RMC_SETTLE;
                    settle_rx_d = 1'b0;
                end
            end
            rmc_pkg::RMC_STBY2:
            begin
                if (load_pend_q)
                begin
                    mode_d      = rmc_pkg::RMC_SETTLE;
                    settle_rx_d = 1'b0;
                    load_pend_d = 1'b0;
                end
            end
            rmc_pkg::RMC_SETTLE:
            begin
                if (set_done)
                begin
                    mode_d     = settle_rx_q ? rmc_pkg::RMC_RX : rmc_pkg::RMC_TX;
                    tx_start_d = ~settle_rx_q;
                end
            end
            rmc_pkg::RMC_RX:
            begin
                if (CTRL.auto_protocol_en && !prx)
                begin
                    mode_d      = rmc_pkg::RMC_SETTLE;
                    settle_rx_d = 1'b0;
                end
            end
            rmc_pkg::RMC_TX:
            begin
                if (tx_over)
                begin
                    tx_abort_d = 1'b1;
                    mode_d     = rmc_pkg::RMC_STBY1;
                    sent_d     = 1'b1;
                end
                else if (TX_PKT_DONE)
                begin
                    sent_d  = 1'b1;
                    pulse_d = 1'b0;
                    if (!ce)
                    begin
                        mode_d = rmc_pkg::RMC_STBY1;
                    end
                    else if (!TX_FIFO_EMPTY)
                    begin
                        tx_start_d = 1'b1;
                        sent_d     = 1'b0;
                    end
                    else
                    begin
                        mode_d      = rmc_pkg::RMC_STBY2;
                        load_pend_d = 1'b0;
                    end
                end
                else if (CTRL.auto_protocol_en && prx && ce)
                begin
                    mode_d      = rmc_pkg::RMC_SETTLE;
                    settle_rx_d = 1'b1;
                end
            end
            default:
            begin
                mode_d = rmc_pkg::RMC_PDN;
            end
        endcase
        // enable low returns to standby-I
        // A pulse shorter than the settle time must still reach transmit, so that settle is kept.
        if (!ce && mode_q != rmc_pkg::RMC_PDN && mode_q != rmc_pkg::RMC_PU_WT && mode_q != rmc_pkg::RMC_TX
            && !(mode_q == rmc_pkg::RMC_SETTLE && !settle_rx_q && pulse_q))
        begin
            mode_d = rmc_pkg::RMC_STBY1;
        end
        if (!pu)
        begin
            mode_d = rmc_pkg::RMC_PDN;
        end
        if (SYNC_RST)
        begin
            mode_d      = rmc_pkg::RMC_PDN;
            load_pend_d = 1'b0;
            pulse_d     = 1'b0;
            sent_d      = 1'b0;
        end
    end

    always_comb
    begin
        rx_store_d = 1'b0;
        rx_disc_d  = 1'b0;
        det_f_d    = det_f_q;
        rpd_d      = rpd_q;
        rate_d     = CTRL.air_rate_select;
        // Three-stage filter: a change counts once the last two stages agree.
        if (det_s_q[1] == det_s_q[2])
        begin
            det_f_d = det_s_q[2];
        end
        if (mode_q == rmc_pkg::RMC_RX && valid_pkt)
        begin
            rx_disc_d  = RX_FIFO_FULL;
            rx_store_d = ~RX_FIFO_FULL;
        end
        // freeze on packet or enable low
        if (mode_q == rmc_pkg::RMC_RX && ce && !valid_pkt)
        begin
            rpd_d = rpd_done;
        end
        // rate held while transmitting or receiving
        if (mode_q == rmc_pkg::RMC_TX || mode_q == rmc_pkg::RMC_RX)
        begin
            rate_d = rate_q;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            mode_q      <= rmc_pkg::RMC_PDN;
            settle_rx_q <= 1'b0;
            pulse_q     <= 1'b0;
            sent_q      <= 1'b0;
            load_pend_q <= 1'b0;
            det_s_q     <= 3'h0;
            det_f_q     <= 1'b0;
            rpd_q       <= 1'b0;
            rx_store_q  <= 1'b0;
            rx_disc_q   <= 1'b0;
            tx_start_q  <= 1'b0;
            tx_abort_q  <= 1'b0;
            rate_q      <= `RMC_RATE_1M;
            cs_q        <= 1'b1;
            ce_q        <= 1'b0;
        end
        else
        begin
            mode_q      <= mode_d;
            settle_rx_q <= settle_rx_d;
            pulse_q     <= pulse_d;
            sent_q      <= sent_d;
            load_pend_q <= load_pend_d;
            det_s_q     <= {det_s_q[1:0], POWER_DETECT_RAW};
            det_f_q     <= det_f_d;
            rpd_q       <= rpd_d;
            rx_store_q  <= rx_store_d;
            rx_disc_q   <= rx_disc_d;
            tx_start_q  <= tx_start_d;
            tx_abort_q  <= tx_abort_d;
            rate_q      <= rate_d;
            cs_q        <= CHIP_SELECT_B;
            ce_q        <= ce;
        end
    end

    // SPI kept usable in all modes
    assign SPI_ENABLE = 1'b1;
    assign RX_STORE   = rx_store_q;
    assign RX_DISCARD = rx_disc_q;
    assign TX_START   = tx_start_q;
    assign TX_ABORT   = tx_abort_q;
    assign SYNTH_ON   = mode_q == rmc_pkg::RMC_SETTLE || mode_q == rmc_pkg::RMC_RX || mode_q == rmc_pkg::RMC_TX;
    assign CLK_BUF_ON = mode_q == rmc_pkg::RMC_STBY2 || SYNTH_ON;
    assign AIR_RATE   = rate_q;
    assign RX_ACTIVE  = mode_q == rmc_pkg::RMC_RX;
    assign TX_ACTIVE  = mode_q == rmc_pkg::RMC_TX;
    // flag is register 09 bit 0
    assign RECEIVED_POWER_FLAG = rpd_q;
    assign MODE       = mode_q;
endmodule

// >>> verif/rmc_props.sv
module rmc_props
#(
    parameter int PD2STBY_CYC = 20,
    parameter int STBY2A_CYC  = 16,
    parameter int RPD_CYC     = 10,
    parameter int TXMAX_CYC   = 200
)
(
    input wire logic                  REF_CLK,
    input wire logic                  RST_B,
    input wire rmc_pkg::rmc_ctrl_type CTRL,
    input wire logic                  SYNC_RST,
    input wire logic                  TX_FIFO_EMPTY,
    input wire logic                  RX_FIFO_FULL,
    input wire rmc_pkg::rmc_rxev_type RX_EVENT,
    input wire logic                  TX_PKT_DONE,
    input wire logic                  POWER_DETECT_RAW,
    input wire logic                  RX_STORE,
    input wire logic                  RX_DISCARD,
    input wire logic [1:0]            AIR_RATE,
    input wire logic                  RECEIVED_POWER_FLAG,
    input wire logic [2:0]            MODE
);
    logic live;
    int   pu_q;
    int   st_q;
    int   tx_q;
    int   raw_q;

    assign live = CTRL.power_up_bit && !SYNC_RST;

    // Run-length counters bound the long waits without huge delay ranges.
    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pu_q  <= 0;
            st_q  <= 0;
            tx_q  <= 0;
            raw_q <= 0;
        end
        else
        begin
            pu_q  <= (MODE == 3'h1) ? pu_q + 1 : 0;
            st_q  <= (MODE == 3'h2) ? st_q + 1 : 0;
            tx_q  <= (MODE == 3'h7) ? tx_q + 1 : 0;
            raw_q <= POWER_DETECT_RAW ? raw_q + 1 : 0;
        end
    end

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);

    sequence tx_end_low;
        live && MODE == 3'h7 && TX_PKT_DONE && !CTRL.chip_enable;
    endsequence
    sequence tx_end_empty;
        live && MODE == 3'h7 && TX_PKT_DONE && CTRL.chip_enable && TX_FIFO_EMPTY && !CTRL.primary_receiver_select;
    endsequence
    sequence rx_good;
        live && MODE == 3'h6 && CTRL.chip_enable && (&RX_EVENT);
    endsequence

    AST_PDN_FORCE: assert property (!CTRL.power_up_bit |=> MODE == 3'h0)
        else $error("power down not forced");
    AST_PU_TIME: assert property (pu_q <= PD2STBY_CYC + 3)
        else $error("power-up wait too long");
    AST_RX_LEAVE: assert property (live && MODE == 3'h6 && !CTRL.chip_enable |=> MODE == 3'h3)
        else $error("receive kept without enable");
    AST_RX_ENTRY: assert property ($rose(MODE == 3'h6) |-> $past(MODE) == 3'h2 && $past(CTRL.chip_enable))
        else $error("receive entered without settle");
    AST_SETTLE_TIME: assert property (st_q <= STBY2A_CYC + 3)
        else $error("settle too long");
    AST_TX_TO_STBY1: assert property (tx_end_low |=> MODE == 3'h3)
        else $error("no standby-I after packet");
    AST_TX_TO_STBY2: assert property (tx_end_empty |=> MODE == 3'h5)
        else $error("no standby-II after packet");
    AST_TX_LIMIT: assert property (tx_q <= TXMAX_CYC + 3)
        else $error("transmit held too long");
    AST_RX_STORE: assert property (rx_good ##0 !RX_FIFO_FULL |=> RX_STORE && !RX_DISCARD)
        else $error("good packet not stored");
    AST_RX_DROP: assert property (rx_good ##0 RX_FIFO_FULL |=> RX_DISCARD && !RX_STORE)
        else $error("packet not dropped when full");
    AST_RPD_FILTER: assert property ($rose(RECEIVED_POWER_FLAG) |-> raw_q >= RPD_CYC)
        else $error("power flag rose too early");
    AST_RPD_HOLD: assert property ((MODE != 3'h6 || !CTRL.chip_enable) && !SYNC_RST |=> $stable(RECEIVED_POWER_FLAG))
        else $error("power flag not frozen");
    AST_RATE: assert property (MODE != 3'h6 && MODE != 3'h7 && !SYNC_RST |=> AIR_RATE == $past(CTRL.air_rate_select))
        else $error("air rate not followed");
endmodule

bind rmc_top rmc_props
#(
    .PD2STBY_CYC(PD2STBY_CYC),
    .STBY2A_CYC(STBY2A_CYC),
    .RPD_CYC(RPD_CYC),
    .TXMAX_CYC(TXMAX_CYC)
)
u_props (.REF_CLK(REF_CLK), .RST_B(RST_B), .CTRL(CTRL), .SYNC_RST(SYNC_RST), .TX_FIFO_EMPTY(TX_FIFO_EMPTY),
    .RX_FIFO_FULL(RX_FIFO_FULL), .RX_EVENT(RX_EVENT), .TX_PKT_DONE(TX_PKT_DONE), .POWER_DETECT_RAW(POWER_DETECT_RAW),
    .RX_STORE(RX_STORE), .RX_DISCARD(RX_DISCARD), .AIR_RATE(AIR_RATE), .RECEIVED_POWER_FLAG(RECEIVED_POWER_FLAG),
    .MODE(MODE));

// >>> verif/rmc_link_model.sv
module rmc_link_model
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic load,
    input  wire logic stall,
    input  wire logic tx_start,
    input  wire logic tx_abort,
    input  wire logic rx_store,
    output logic      tx_fifo_empty,
    output logic      rx_fifo_full,
    output logic      tx_pkt_done
);
    timeunit 1ns;
    timeprecision 100ps;
    int tx_n_q;
    int rx_n_q;
    int busy_q;

    assign tx_fifo_empty = (tx_n_q == 0);
    assign rx_fifo_full = (rx_n_q == 2);

    // A stall keeps the packet on air for good, so only the watchdog can end it.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_n_q      <= 0;
            rx_n_q      <= 0;
            busy_q      <= 0;
            tx_pkt_done <= 1'b0;
        end
        else
        begin
            tx_n_q      <= tx_n_q + int'(load) - int'(tx_start);
            rx_n_q      <= (rx_store && rx_n_q < 2) ? rx_n_q + 1 : rx_n_q;
            tx_pkt_done <= busy_q == 1 && !stall && !tx_abort;
            if (tx_start)
                busy_q <= 12;
            else if (tx_abort)
                busy_q <= 0;
            else if (busy_q > 0 && !stall)
                busy_q <= busy_q - 1;
        end
    end
endmodule

// >>> verif/radio_mode_controller_tb.sv
module radio_mode_controller_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                  clk = 1'b0;
    logic                  rst_b = 1'b0;
    rmc_pkg::rmc_ctrl_type ctrl = '0;
    rmc_pkg::rmc_rxev_type rxev = '0;
    logic                  sync_rst = 1'b0;
    logic                  cs_b = 1'b1;
    logic                  raw = 1'b0;
    logic                  load = 1'b0;
    logic                  stall = 1'b0;
    logic                  tx_empty, rx_full, pkt_done, rx_store, rx_drop, tx_start, tx_abort, spi_en, flag;
    logic                  synth, clk_buf, rx_act, tx_act;
    logic [1:0]            rate;
    logic [2:0]            mode;
    int                    errors = 0;
    int                    checks_done = 0;
    int                    starts = 0;
    int                    stores = 0;
    int                    drops = 0;
    int                    aborts = 0;

    rmc_top #(.PD2STBY_CYC(20), .STBY2A_CYC(16), .CE_MIN_CYC(8), .RPD_CYC(10), .TXMAX_CYC(200)) dut
    (.REF_CLK(clk), .RST_B(rst_b), .CTRL(ctrl), .SYNC_RST(sync_rst), .CHIP_SELECT_B(cs_b), .TX_FIFO_EMPTY(tx_empty),
     .RX_FIFO_FULL(rx_full), .RX_EVENT(rxev), .TX_PKT_DONE(pkt_done), .POWER_DETECT_RAW(raw), .RX_STORE(rx_store),
     .RX_DISCARD(rx_drop), .TX_START(tx_start), .TX_ABORT(tx_abort), .SYNTH_ON(synth), .CLK_BUF_ON(clk_buf),
     .SPI_ENABLE(spi_en), .AIR_RATE(rate), .RX_ACTIVE(rx_act), .TX_ACTIVE(tx_act), .RECEIVED_POWER_FLAG(flag),
     .MODE(mode));

    rmc_link_model u_link
    (.clk(clk), .rst_b(rst_b), .load(load), .stall(stall), .tx_start(tx_start), .tx_abort(tx_abort),
     .rx_store(rx_store), .tx_fifo_empty(tx_empty), .rx_fifo_full(rx_full), .tx_pkt_done(pkt_done));

    initial forever #2.5 clk = ~clk;

    always @(posedge clk)
    begin
        starts += (tx_start === 1'b1);
        stores += (rx_store === 1'b1);
        drops += (rx_drop === 1'b1);
        aborts += (tx_abort === 1'b1);
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic wait_mode(input logic [2:0] exp, input int lim);
        for (int n = 0; n < lim && mode !== exp; n++)
            @(negedge clk);
        cmp("mode", 8'(exp), 8'(mode));
    endtask

    // Chip-select rising after the load marks the end of an upload.
    task automatic upload;
        cs_b = 1'b0;
        load = 1'b1;
        cyc(1);
        load = 1'b0;
        cs_b = 1'b1;
        cyc(1);
    endtask

    task automatic close_out;
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out;
    end

    initial
    begin
        int s0;
        int a0;
        cyc(8);
        rst_b = 1'b1;
        cmp("mode", 8'h00, 8'(mode));
        cmp("spi", 8'h01, 8'(spi_en));
        ctrl.power_up_bit = 1'b1;
        wait_mode(3'h3, 60);
        cmp("spi", 8'h01, 8'(spi_en));
        for (int r = 2; r >= 0; r--)
        begin
            ctrl.air_rate_select = 2'(r);
            cyc(2);
            cmp("rate", 8'(r), 8'(rate));
        end
        $display("test setup finished");
        s0 = starts;
        upload();
        upload();
        ctrl.chip_enable = 1'b1;
        cyc(12);
        ctrl.chip_enable = 1'b0;
        wait_mode(3'h7, 80);
        wait_mode(3'h3, 40);
        cmp("starts", 8'(s0 + 1), 8'(starts));
        ctrl.chip_enable = 1'b1;
        cyc(4);
        ctrl.chip_enable = 1'b0;
        cyc(60);
        cmp("starts", 8'(s0 + 1), 8'(starts));
        ctrl.chip_enable = 1'b1;
        wait_mode(3'h5, 120);
        cmp("clkbuf", 8'h01, 8'(clk_buf));
        cmp("synth", 8'h00, 8'(synth));
        cmp("starts", 8'(s0 + 2), 8'(starts));
        cyc(10);
        upload();
        wait_mode(3'h7, 60);
        cmp("txact", 8'h01, 8'(tx_act));
        wait_mode(3'h5, 60);
        cmp("starts", 8'(s0 + 3), 8'(starts));
        ctrl.chip_enable = 1'b0;
        wait_mode(3'h3, 10);
        $display("test transmit finished");
        ctrl.primary_receiver_select = 1'b1;
        ctrl.chip_enable = 1'b1;
        wait_mode(3'h6, 60);
        cmp("rxact", 8'h01, 8'(rx_act));
        cmp("synth", 8'h01, 8'(synth));
        raw = 1'b1;
        cyc(6);
        cmp("flag", 8'h00, 8'(flag));
        cyc(20);
        cmp("flag", 8'h01, 8'(flag));
        for (int k = 0; k < 4; k++)
        begin
            rxev = rmc_pkg::rmc_rxev_type'((k == 0) ? 3'h6 : 3'h7);
            cyc(1);
            rxev = '0;
            cyc(3);
        end
        cmp("stores", 8'h02, 8'(stores));
        cmp("drops", 8'h01, 8'(drops));
        cmp("mode", 8'h06, 8'(mode));
        ctrl.chip_enable = 1'b0;
        raw = 1'b0;
        wait_mode(3'h3, 10);
        cyc(10);
        cmp("flag", 8'h01, 8'(flag));
        $display("test receive finished");
        ctrl.primary_receiver_select = 1'b0;
        stall = 1'b1;
        a0 = aborts;
        upload();
        ctrl.chip_enable = 1'b1;
        for (int n = 0; n < 400 && aborts == a0; n++)
            @(negedge clk);
        cmp("aborts", 8'(a0 + 1), 8'(aborts));
        ctrl.power_up_bit = 1'b0;
        stall = 1'b0;
        cyc(2);
        cmp("mode", 8'h00, 8'(mode));
        ctrl.power_up_bit = 1'b1;
        wait_mode(3'h3, 60);
        cmp("rate", 8'h00, 8'(rate));
        sync_rst = 1'b1;
        cyc(2);
        cmp("mode", 8'h00, 8'(mode));
        sync_rst = 1'b0;
        $display("test watchdog finished");
        close_out;
    end
endmodule
